// File: common/rcr_pkg.sv
// shared constants and types for the reset cause recorder
package rcr_pkg;

    localparam int unsigned ADDR_W = 15;

    // program counter targets
    localparam logic [14:0] RESET_VECTOR = 15'h0000;
    localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
    localparam logic [14:0] PC_STEP      = 15'h0001;

    // status flag reset values after power-on
    localparam logic TIMEOUT_POR   = 1'b1;
    localparam logic POWERDOWN_POR = 1'b1;

    // power control flag values after power-on (brown-out left at zero)
    localparam logic STK_OVER_POR  = 1'b0;
    localparam logic STK_UNDER_POR = 1'b0;
    localparam logic WDT_RST_POR   = 1'b1;
    localparam logic PIN_RST_POR   = 1'b1;
    localparam logic INSTR_RST_POR = 1'b1;
    localparam logic POWERON_POR   = 1'b0;
    localparam logic BROWNOUT_POR  = 1'b0;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } rcr_status_t;

    typedef struct packed {
        logic stack_over_flag;
        logic stack_under_flag;
        logic watchdog_reset_flag;
        logic pin_reset_flag;
        logic instr_reset_flag;
        logic poweron_flag;
        logic brownout_flag;
    } rcr_power_control_reg_t;

    typedef struct packed {
        logic por;
        logic bor;
        logic wdt_reset;
        logic wdt_wake;
        logic pin_reset;
        logic irq_wake;
        logic reset_instr;
        logic stack_over;
        logic stack_under;
    } rcr_events_t;

    typedef enum logic [1:0] {
        RCR_TGT_NONE,
        RCR_TGT_RESET,
        RCR_TGT_NEXT
    } rcr_target_t;

endpackage

// File: rtl/rcr_pin_sync.sv
// two-stage synchroniser for the external clear pin
`timescale 1ns/1ps
module rcr_pin_sync
(
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    output logic      pin_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } rcr_sync_state_t;

    rcr_sync_state_t state_reg;
    rcr_sync_state_t state_next;

    always_comb
    begin
        state_next.meta = pin_i;
        state_next.sync = state_reg.meta;
    end

    always_ff @(posedge sys_clk_i)
    begin
        // reset to the released level, or the edge detector sees a fall
        if (sys_rst_i)
            state_reg <= '1;
        else
            state_reg <= state_next;
    end

    assign pin_o = state_reg.sync;
endmodule

// File: rtl/rcr_recorder.sv
// reset and wake cause flags with program counter target selection
//
// Notes on behaviour
// [RULE1] every reset updates cause flags, others kept
// [RULE2] power-on loads the documented flag pattern
// [RULE3] clear pin running: clear pin flag, vector zero
// [RULE4] clear pin asleep: also timeout set, powerdown clear
// [RULE5] watchdog sleep wake clears timeout and powerdown
// [RULE6] interrupt wake sets timeout, clears powerdown
// [RULE7] interrupt wake with enable then vectors
// [RULE8] enabled stack overflow resets, sets flag
// [RULE9] enabled stack underflow resets, sets flag
// [RULE10] watchdog or instruction reset clears own flag
// [RULE11] brown-out loads its documented flag pattern
`timescale 1ns/1ps
module rcr_recorder
(
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                por_pulse_i,
    input  wire logic                bor_pulse_i,
    input  wire logic                wdt_expire_i,
    input  wire logic                external_clear_pin_i,
    input  wire logic                reset_instr_i,
    input  wire logic                stack_over_i,
    input  wire logic                stack_under_i,
    input  wire logic                irq_wake_i,
    input  wire logic                sleeping_i,
    input  wire logic                global_irq_enable_i,
    input  wire logic                stack_fault_reset_enable_i,
    input  wire logic [14:0]         pc_i,
    output rcr_pkg::rcr_status_t     status_o,
    output rcr_pkg::rcr_power_control_reg_t       power_control_reg_o,
    output logic                     core_reset_o,
    output logic                     pc_load_o,
    output logic [14:0]              pc_target_o,
    output logic                     irq_vector_o
);
    // ***************************************************************
    // pin synchroniser and event decode
    // ***************************************************************
    logic pin_level;
    rcr_pkg::rcr_events_t ev;

    rcr_pin_sync rcr_pin_sync_inst
    (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (external_clear_pin_i),
        .pin_o     (pin_level)
    );

    typedef struct packed {
        rcr_pkg::rcr_status_t status;
        rcr_pkg::rcr_power_control_reg_t   power_control_reg;
        logic                 pin_prev;
        logic                 irq_pending;
        logic                 core_reset;
        logic                 pc_load;
        logic [14:0]          pc_target;
        logic                 irq_vector;
    } rcr_state_t;

    rcr_state_t state_reg;
    rcr_state_t state_next;

    // clear pin is active low; its falling edge is the reset event
    always_comb
    begin
        ev.por         = por_pulse_i;
        ev.bor         = bor_pulse_i;
        ev.wdt_reset   = wdt_expire_i & ~sleeping_i;
        ev.wdt_wake    = wdt_expire_i & sleeping_i;
        ev.pin_reset   = state_reg.pin_prev & ~pin_level;
        ev.irq_wake    = irq_wake_i & sleeping_i;
        ev.reset_instr = reset_instr_i;
        // [RULE8] gated stack overflow
        ev.stack_over  = stack_over_i & stack_fault_reset_enable_i;
        // [RULE9] gated stack underflow
        ev.stack_under = stack_under_i & stack_fault_reset_enable_i;
    end

    // ***************************************************************
    // flag update, priority power-on over brown-out over the rest
    // ***************************************************************
    always_comb
    begin
        state_next            = state_reg;
        state_next.pin_prev   = pin_level;
        state_next.core_reset = 1'b0;
        state_next.pc_load    = 1'b0;
        state_next.irq_vector = 1'b0;
        // [RULE7] vector one cycle after the next instruction
        if (state_reg.irq_pending)
        begin
            state_next.irq_pending = 1'b0;
            state_next.pc_load     = 1'b1;
            state_next.irq_vector  = 1'b1;
            state_next.pc_target   = rcr_pkg::IRQ_VECTOR;
        end
        if (ev.por)
        begin
            // [RULE2] power-on pattern
            state_next.status.timeout_flag        = rcr_pkg::TIMEOUT_POR;
            state_next.status.powerdown_flag      = rcr_pkg::POWERDOWN_POR;
            state_next.power_control_reg.stack_over_flag       = rcr_pkg::STK_OVER_POR;
            state_next.power_control_reg.stack_under_flag      = rcr_pkg::STK_UNDER_POR;
            state_next.power_control_reg.watchdog_reset_flag   = rcr_pkg::WDT_RST_POR;
            state_next.power_control_reg.pin_reset_flag        = rcr_pkg::PIN_RST_POR;
            state_next.power_control_reg.instr_reset_flag      = rcr_pkg::INSTR_RST_POR;
            state_next.power_control_reg.poweron_flag          = rcr_pkg::POWERON_POR;
            state_next.power_control_reg.brownout_flag         = rcr_pkg::BROWNOUT_POR;
            state_next.irq_pending                = 1'b0;
        end
        else if (ev.bor)
        begin
            // [RULE11] brown-out pattern
            state_next.status.timeout_flag        = 1'b1;
            state_next.status.powerdown_flag      = 1'b1;
            state_next.power_control_reg.stack_over_flag       = 1'b0;
            state_next.power_control_reg.stack_under_flag      = 1'b0;
            state_next.power_control_reg.pin_reset_flag        = 1'b1;
            state_next.power_control_reg.instr_reset_flag      = 1'b1;
            state_next.power_control_reg.brownout_flag         = 1'b0;
            state_next.irq_pending                = 1'b0;
        end
        else
        begin
            // [RULE1] independent sources, untouched flags kept
            if (ev.wdt_reset)
            begin
                // [RULE10] watchdog reset flags
                state_next.power_control_reg.watchdog_reset_flag = 1'b0;
                state_next.status.timeout_flag      = 1'b0;
            end
            if (ev.pin_reset)
            begin
                // [RULE3] clear pin flag
                state_next.power_control_reg.pin_reset_flag = 1'b0;
                if (sleeping_i)
                begin
                    // [RULE4] sleep variant
                    state_next.status.timeout_flag   = 1'b1;
                    state_next.status.powerdown_flag = 1'b0;
                end
            end
            if (ev.wdt_wake)
            begin
                // [RULE5] watchdog wake
                state_next.status.timeout_flag   = 1'b0;
                state_next.status.powerdown_flag = 1'b0;
            end
            if (ev.irq_wake && !ev.wdt_wake)
            begin
                // [RULE6] interrupt wake
                state_next.status.timeout_flag   = 1'b1;
                state_next.status.powerdown_flag = 1'b0;
            end
            if (ev.reset_instr)
            begin
                // [RULE10] instruction reset flag
                state_next.power_control_reg.instr_reset_flag = 1'b0;
            end
            if (ev.stack_over)
            begin
                // [RULE8] overflow flag
                state_next.power_control_reg.stack_over_flag = 1'b1;
            end
            if (ev.stack_under)
            begin
                // [RULE9] underflow flag
                state_next.power_control_reg.stack_under_flag = 1'b1;
            end
        end

        // ***********************************************************
        // program counter target; a reset beats a wake
        // ***********************************************************
        if (ev.por || ev.bor || ev.wdt_reset || ev.pin_reset
            || ev.reset_instr || ev.stack_over || ev.stack_under)
        begin
            // [RULE3] restart at zero
            state_next.core_reset  = 1'b1;
            state_next.pc_load     = 1'b1;
            state_next.irq_vector  = 1'b0;
            state_next.irq_pending = 1'b0;
            state_next.pc_target   = rcr_pkg::RESET_VECTOR;
        end
        else if (ev.wdt_wake || ev.irq_wake)
        begin
            // [RULE5] continue after the sleep
            state_next.pc_load    = 1'b1;
            state_next.irq_vector = 1'b0;
            state_next.pc_target  = pc_i + rcr_pkg::PC_STEP;
            // [RULE7] remember vector request
            state_next.irq_pending = ev.irq_wake & ~ev.wdt_wake
                                     & global_irq_enable_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg                            <= '0;
            state_reg.status.timeout_flag        <= rcr_pkg::TIMEOUT_POR;
            state_reg.status.powerdown_flag      <= rcr_pkg::POWERDOWN_POR;
            state_reg.power_control_reg.watchdog_reset_flag   <= rcr_pkg::WDT_RST_POR;
            state_reg.power_control_reg.pin_reset_flag        <= rcr_pkg::PIN_RST_POR;
            state_reg.power_control_reg.instr_reset_flag      <= rcr_pkg::INSTR_RST_POR;
            state_reg.pin_prev                   <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    assign status_o            = state_reg.status;
    assign power_control_reg_o = state_reg.power_control_reg;
    assign core_reset_o        = state_reg.core_reset;
    assign pc_load_o           = state_reg.pc_load;
    assign pc_target_o         = state_reg.pc_target;
    assign irq_vector_o        = state_reg.irq_vector;
endmodule

// File: test/rcr_checker.sv
// assertion checker bound to the reset cause recorder ports
`timescale 1ns/1ps
module rcr_checker
(
    input wire logic                 sys_clk_i,
    input wire logic                 sys_rst_i,
    input wire logic                 por_pulse_i,
    input wire logic                 bor_pulse_i,
    input wire logic                 wdt_expire_i,
    input wire logic                 external_clear_pin_i,
    input wire logic                 reset_instr_i,
    input wire logic                 stack_over_i,
    input wire logic                 stack_under_i,
    input wire logic                 irq_wake_i,
    input wire logic                 sleeping_i,
    input wire logic                 global_irq_enable_i,
    input wire logic                 stack_fault_reset_enable_i,
    input wire logic [14:0]          pc_i,
    input wire rcr_pkg::rcr_status_t status_o,
    input wire rcr_pkg::rcr_power_control_reg_t   power_control_reg_o,
    input wire logic                 core_reset_o,
    input wire logic                 pc_load_o,
    input wire logic [14:0]          pc_target_o,
    input wire logic                 irq_vector_o
);
    logic [3:0] pin_hist_reg;
    logic       calm;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // pin history keeps a pending clear-pin event out of the quiet test
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            pin_hist_reg <= 4'h0;
        else
            pin_hist_reg <= {pin_hist_reg[2:0], external_clear_pin_i};
    end
    assign calm = !por_pulse_i && !bor_pulse_i && !reset_instr_i
        && !stack_over_i && !stack_under_i && external_clear_pin_i
        && pin_hist_reg == 4'hf;

    sequence s_irq_wake;
        calm && irq_wake_i && sleeping_i && !wdt_expire_i
            && global_irq_enable_i;
    endsequence
    sequence s_vector;
        pc_load_o && irq_vector_o && pc_target_o == rcr_pkg::IRQ_VECTOR;
    endsequence

    a_por_pattern: assert property (por_pulse_i |=>
        status_o == 2'h3 && power_control_reg_o == 7'h1c)
        else $error("power-on flag pattern wrong");
    a_bor_pattern: assert property (bor_pulse_i && !por_pulse_i |=>
        status_o == 2'h3 && power_control_reg_o[6:5] == 2'h0
        && power_control_reg_o[3:2] == 2'h3
        && !power_control_reg_o.brownout_flag && core_reset_o)
        else $error("brown-out flag pattern wrong");
    a_instr_clear: assert property (reset_instr_i && !por_pulse_i
        && !bor_pulse_i |=> !power_control_reg_o.instr_reset_flag
        && core_reset_o && pc_target_o == rcr_pkg::RESET_VECTOR)
        else $error("reset instruction not recorded");
    a_wake_no_reset: assert property (calm && sleeping_i
        && (wdt_expire_i || irq_wake_i) |=> !core_reset_o)
        else $error("wake raised a core reset");
    a_wdt_wake: assert property (calm && wdt_expire_i && sleeping_i |=>
        status_o == 2'h0 && pc_target_o == $past(pc_i) + rcr_pkg::PC_STEP)
        else $error("watchdog wake wrong");
    a_irq_wake: assert property (s_irq_wake |=> status_o == 2'h2
        && pc_target_o == $past(pc_i) + rcr_pkg::PC_STEP ##1 s_vector)
        else $error("interrupt wake sequence wrong");
    a_over_reset: assert property (stack_over_i
        && stack_fault_reset_enable_i && !por_pulse_i && !bor_pulse_i |=>
        power_control_reg_o.stack_over_flag && core_reset_o)
        else $error("stack overflow reset missing");
    a_under_reset: assert property (stack_under_i
        && stack_fault_reset_enable_i && !por_pulse_i && !bor_pulse_i |=>
        power_control_reg_o.stack_under_flag && core_reset_o)
        else $error("stack underflow reset missing");
    a_pin_reset: assert property (pin_hist_reg == 4'hf
        && !external_clear_pin_i |-> ##[2:4] (pc_load_o
        && !power_control_reg_o.pin_reset_flag))
        else $error("clear pin reset not recorded");
    a_flags_hold: assert property (calm && !wdt_expire_i
        && !(irq_wake_i && sleeping_i) |=> $stable(status_o)
        && $stable(power_control_reg_o))
        else $error("flags changed with no event");
endmodule

// File: test/rcr_recorder_tb.sv
// self-checking bench for the reset cause recorder
`timescale 1ns/1ps
module rcr_recorder_tb;
    logic                 sys_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    logic [6:0]           ev = 7'h00;
    logic [1:0]           cfg = 2'h0;
    logic                 external_clear_pin_i = 1'b1;
    logic                 sleeping_i = 1'b0;
    logic [14:0]          pc_i = 15'h0123;
    wire logic            por_pulse_i = ev[6];
    wire logic            bor_pulse_i = ev[5];
    wire logic            wdt_expire_i = ev[4];
    wire logic            reset_instr_i = ev[3];
    wire logic            stack_over_i = ev[2];
    wire logic            stack_under_i = ev[1];
    wire logic            irq_wake_i = ev[0];
    wire logic            global_irq_enable_i = cfg[1];
    wire logic            stack_fault_reset_enable_i = cfg[0];
    rcr_pkg::rcr_status_t status_o;
    rcr_pkg::rcr_power_control_reg_t   power_control_reg_o;
    logic                 core_reset_o;
    logic                 pc_load_o;
    logic [14:0]          pc_target_o;
    logic                 irq_vector_o;
    int                   fail_count = 0;
    int                   comparisons = 0;
    int                   cycles = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    rcr_recorder rcr_recorder_inst (.*);

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // timeout well above the fewer than one hundred cycles the sequence needs
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk_flags(input logic [8:0] exp_v);
        comparisons++;
        if ({status_o, power_control_reg_o} !== exp_v)
        begin
            fail_count++;
            $display("Error flags expected %h seen %h", exp_v,
                {status_o, power_control_reg_o});
        end
    endtask

    task automatic chk_pc(input logic [16:0] exp_v);
        comparisons++;
        if ({irq_vector_o, pc_load_o, pc_target_o} !== exp_v)
        begin
            fail_count++;
            $display("Error pc expected %h seen %h", exp_v,
                {irq_vector_o, pc_load_o, pc_target_o});
        end
    endtask

    // one event pulse, answer sampled the cycle after it is taken
    task automatic step(input logic [6:0] e, input logic slp,
        input logic [1:0] c, input logic [16:0] ep, input logic [8:0] ef);
        @(posedge sys_clk_i);
        ev <= e;
        sleeping_i <= slp;
        cfg <= c;
        @(posedge sys_clk_i);
        ev <= 7'h00;
        #1;
        chk_pc(ep);
        chk_flags(ef);
    endtask

    // pin passes a synchroniser, so wait for the load under a bound
    task automatic pin(input logic slp, input logic [8:0] ef);
        int n;
        @(posedge sys_clk_i);
        external_clear_pin_i <= 1'b0;
        sleeping_i <= slp;
        @(posedge sys_clk_i);
        #1;
        for (n = 0; n < 8 && pc_load_o !== 1'b1; n++)
        begin
            @(posedge sys_clk_i);
            #1;
        end
        chk_pc(17'h08000);
        chk_flags(ef);
        @(posedge sys_clk_i);
        external_clear_pin_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk_flags(9'h19c);
        step(7'h08, 1'h0, 2'h0, 17'h08000, 9'h198);
        step(7'h10, 1'h0, 2'h0, 17'h08000, 9'h088);
        step(7'h04, 1'h0, 2'h0, 17'h00000, 9'h088);
        step(7'h04, 1'h0, 2'h1, 17'h08000, 9'h0c8);
        step(7'h02, 1'h0, 2'h1, 17'h08000, 9'h0e8);
        pin(1'h0, 9'h0e0);
        step(7'h10, 1'h1, 2'h1, 17'h08124, 9'h060);
        pin(1'h1, 9'h160);
        step(7'h10, 1'h1, 2'h1, 17'h08124, 9'h060);
        step(7'h01, 1'h1, 2'h1, 17'h08124, 9'h160);
        @(posedge sys_clk_i);
        #1;
        chk_pc(17'h00124);
        @(posedge sys_clk_i);
        pc_i <= 15'h7ffe;
        step(7'h01, 1'h1, 2'h3, 17'h0ffff, 9'h160);
        @(posedge sys_clk_i);
        #1;
        chk_pc(17'h18004);
        step(7'h01, 1'h0, 2'h3, 17'h00004, 9'h160);
        step(7'h20, 1'h0, 2'h3, 17'h08000, 9'h18c);
        step(7'h40, 1'h0, 2'h3, 17'h08000, 9'h19c);
        print_verdict();
    end
endmodule

bind rcr_recorder rcr_checker rcr_checker_inst (.*);
